// [hdl/clock_tree_pkg.sv]
package clock_tree_pkg;
  // Divider field width (ratio = setting + 1)
  localparam int          DIV_W        = 3;
  localparam logic [2:0]  DIV_RESET    = 3'h0;
  // Selector encoding for the system clock source
  localparam logic        SEL_FREE_RUN = 1'h0;
  localparam logic        SEL_PLL      = 1'h1;
  localparam logic        SEL_RESET    = 1'h0;
  // Peripheral-local divider width
  localparam int          PDIV_W       = 4;
  localparam logic [3:0]  PDIV_RESET   = 4'h0;
  // Number of peripheral consumers
  localparam int          NUM_PERIPH   = 4;
  // Wake source indices
  localparam int          WAKE_GPIO    = 0;
  localparam int          WAKE_RTC     = 1;
  localparam int          WAKE_WDT     = 2;
  localparam int          NUM_WAKE     = 3;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP_ENTER, ST_DEEP_SLEEP} power_state_t;
endpackage

// [hdl/clock_tree.sv]
`timescale 1ns/1ps
// Overview of operation
// - Peripheral branch has 3-bit divider and software gate before deep sleep.
// - Each peripheral applies its own further division of peripheral branch enable.
// - Auxiliary branch has own 3-bit divider, gated off automatically in deep sleep.
// - Auxiliary branch goes only to the PWM timer output.
// - Bus branch has 3-bit divider and software gate before deep sleep.
// - Bus branch clocks the processor core and memory controller.
// - Peripheral divider is fed by the bus branch output.
// - Deep sleep stops core and peripherals; free-running logic stays active.
// - Wake unit wakes core on GPIO, RTC or watchdog events.
// - System clock selected between free-running clock and PLL output.
// - Auxiliary and bus branches each divide system clock independently.
module clock_tree
  import clock_tree_pkg::*;
#(
  parameter int DIV_WIDTH  = clock_tree_pkg::DIV_W,
  parameter int PDIV_WIDTH = clock_tree_pkg::PDIV_W,
  parameter int NPERIPH    = clock_tree_pkg::NUM_PERIPH
)(
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // Source ticks (one-cycle enables on mclk), PLL lock flag and source select
  input  wire logic                          free_running_clock,
  input  wire logic                          pll_output_clock,
  input  wire logic                          pll_locked_flag,
  input  wire logic                          sys_sel,
  // Branch configuration
  input  wire logic [DIV_WIDTH-1:0]          aux_div,
  input  wire logic [DIV_WIDTH-1:0]          bus_div,
  input  wire logic [DIV_WIDTH-1:0]          periph_div,
  input  wire logic                          bus_gate_en,
  input  wire logic                          periph_gate_en,
  input  wire logic [NPERIPH*PDIV_WIDTH-1:0] periph_local_div,
  // Power control
  input  wire logic                          deep_sleep_req,
  input  wire logic [clock_tree_pkg::NUM_WAKE-1:0] wake_events,
  // Branch enables
  output logic                               sys_tick,
  output logic                               pwm_aux_tick,
  output logic                               core_tick,
  output logic                               mem_tick,
  output logic                               periph_tick,
  output logic [NPERIPH-1:0]                 periph_local_tick,
  output logic                               free_run_tick,
  // Status
  output logic                               deep_sleep_active,
  output logic                               wake_pulse
);
  import clock_tree_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Divider count helper: ratio is setting plus one
  function automatic logic div_hit(input logic [DIV_WIDTH-1:0] cnt, input logic [DIV_WIDTH-1:0] lim);
    div_hit = (cnt == lim);
  endfunction

  logic [DIV_WIDTH-1:0] aux_cnt_reg, bus_cnt_reg, per_cnt_reg;
  logic [DIV_WIDTH-1:0] aux_lim_reg, bus_lim_reg, per_lim_reg;
  logic                 bus_gate_reg, per_gate_reg;
  power_state_t         pstate_reg, pstate_next;

  ////////////////////////////////////////////////////////////////
  // Source selection
  // source mux select
  // Unlocked PLL falls back to free-running source to avoid a dead tree
  wire sel_pll   = (sys_sel == SEL_PLL) && pll_locked_flag;
  wire sys_en    = sel_pll ? pll_output_clock : free_running_clock;
  wire sleeping  = (pstate_reg == ST_DEEP_SLEEP);
  wire any_wake  = |wake_events;

  wire aux_hit   = sys_en && div_hit(aux_cnt_reg, aux_lim_reg);
  wire bus_hit   = sys_en && div_hit(bus_cnt_reg, bus_lim_reg);
  // peripheral divider fed by bus branch
  wire per_hit   = bus_hit && div_hit(per_cnt_reg, per_lim_reg);
  // aux gated automatically in deep sleep
  wire aux_on    = aux_hit && !sleeping;
  // bus gate, also off in deep sleep
  wire bus_on    = bus_hit && bus_gate_reg && !sleeping;
  wire per_on    = per_hit && per_gate_reg && bus_gate_reg && !sleeping;

  ////////////////////////////////////////////////////////////////
  // Divider counters
  // new ratio and gate only latched at end of a branch period
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aux_cnt_reg  <= DIV_RESET;
      aux_lim_reg  <= DIV_RESET;
      bus_cnt_reg  <= DIV_RESET;
      bus_lim_reg  <= DIV_RESET;
      bus_gate_reg <= 1'b1;
    end
    else if (sys_en)
    begin
      aux_cnt_reg <= aux_hit ? DIV_RESET : aux_cnt_reg + 1'b1;
      if (aux_hit)
        aux_lim_reg <= aux_div;
      bus_cnt_reg <= bus_hit ? DIV_RESET : bus_cnt_reg + 1'b1;
      if (bus_hit)
      begin
        bus_lim_reg  <= bus_div;
        bus_gate_reg <= bus_gate_en;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      per_cnt_reg  <= DIV_RESET;
      per_lim_reg  <= DIV_RESET;
      per_gate_reg <= 1'b1;
    end
    else if (bus_hit)
    begin
      per_cnt_reg <= per_hit ? DIV_RESET : per_cnt_reg + 1'b1;
      if (per_hit)
      begin
        per_lim_reg  <= periph_div;
        per_gate_reg <= periph_gate_en;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per-peripheral local dividers
  logic [PDIV_WIDTH-1:0] loc_cnt_reg [NPERIPH];
  logic [PDIV_WIDTH-1:0] loc_lim_reg [NPERIPH];
  logic [NPERIPH-1:0]    loc_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NPERIPH; gi++)
    begin : g_loc
      wire [PDIV_WIDTH-1:0] lim = periph_local_div[gi*PDIV_WIDTH +: PDIV_WIDTH];
      // local ratio latched at its own period end, no short period
      assign loc_hit[gi] = per_on && (loc_cnt_reg[gi] == loc_lim_reg[gi]);
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          loc_cnt_reg[gi] <= PDIV_RESET;
          loc_lim_reg[gi] <= PDIV_RESET;
        end
        else if (per_on)
        begin
          loc_cnt_reg[gi] <= loc_hit[gi] ? PDIV_RESET : loc_cnt_reg[gi] + 1'b1;
          if (loc_hit[gi])
            loc_lim_reg[gi] <= lim;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Deep sleep control
  // enter deep sleep after request, exit on wake
  always_comb
  begin
    pstate_next = pstate_reg;
    case (pstate_reg)
      ST_RUN:         if (deep_sleep_req) pstate_next = ST_SLEEP_ENTER;
      ST_SLEEP_ENTER: pstate_next = any_wake ? ST_RUN : ST_DEEP_SLEEP;
      ST_DEEP_SLEEP:  if (any_wake) pstate_next = ST_RUN;
      default:        pstate_next = ST_RUN;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pstate_reg <= ST_RUN;
    else
      pstate_reg <= pstate_next;
  end

  ////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sys_tick          <= 1'b0;
      pwm_aux_tick      <= 1'b0;
      core_tick         <= 1'b0;
      mem_tick          <= 1'b0;
      periph_tick       <= 1'b0;
      periph_local_tick <= '0;
      free_run_tick     <= 1'b0;
      deep_sleep_active <= 1'b0;
      wake_pulse        <= 1'b0;
    end
    else
    begin
      sys_tick          <= sys_en && !sleeping;
      pwm_aux_tick      <= aux_on;
      // bus branch to core and memory
      core_tick         <= bus_on;
      mem_tick          <= bus_on;
      periph_tick       <= per_on;
      periph_local_tick <= loc_hit;
      // Free-running branch is never gated so watchdog and RTC keep counting
      free_run_tick     <= free_running_clock;
      deep_sleep_active <= (pstate_next == ST_DEEP_SLEEP);
      wake_pulse        <= sleeping && any_wake;
    end
  end
endmodule

// [dv/tick_sink.sv]
`timescale 1ns/1ps
// Branch consumer stand-in: measures spacing and count of its ticks
module tick_sink (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic tick,
  output int        gap,
  output int        hits
);
  int cnt;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      gap <= 0;
      hits <= 0;
    end
    else if (tick)
    begin
      gap <= cnt + 1;
      cnt <= 0;
      hits <= hits + 1;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// [dv/clock_tree_monitor.sv]
`timescale 1ns/1ps
module clock_tree_monitor (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Watched inputs
  input wire logic       free_running_clock,
  input wire logic       pll_locked_flag,
  input wire logic       sys_sel,
  input wire logic       deep_sleep_req,
  input wire logic [2:0] wake_events,
  // Watched outputs
  input wire logic       sys_tick,
  input wire logic       pwm_aux_tick,
  input wire logic       core_tick,
  input wire logic       mem_tick,
  input wire logic       periph_tick,
  input wire logic       free_run_tick,
  input wire logic       deep_sleep_active,
  input wire logic       wake_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence slept_s;
    deep_sleep_active && $past(deep_sleep_active);
  endsequence
  free_run_copy_a: assert property (!$past(rst) |-> free_run_tick == $past(free_running_clock))
    else $error("free run tick wrong");
  bus_pair_a: assert property (core_tick == mem_tick)
    else $error("core and memory ticks differ");
  aux_sleep_off_a: assert property (slept_s |-> !pwm_aux_tick)
    else $error("aux tick in deep sleep");
  sleep_quiet_a: assert property (slept_s |-> !core_tick && !periph_tick)
    else $error("bus tick in deep sleep");
  sys_source_a: assert property (!$past(rst) && !$past(deep_sleep_active) &&
    !($past(sys_sel) && $past(pll_locked_flag)) |-> sys_tick == $past(free_running_clock))
    else $error("system tick source wrong");
  aux_from_sys_a: assert property (pwm_aux_tick |-> sys_tick)
    else $error("aux tick without system tick");
  core_from_sys_a: assert property (core_tick |-> sys_tick)
    else $error("bus tick without system tick");
  wake_cause_a: assert property (wake_pulse |-> $past(deep_sleep_active) && $past(|wake_events))
    else $error("wake without cause");
  wake_exit_a: assert property ($fell(deep_sleep_active) |-> wake_pulse)
    else $error("sleep left without wake");
  sleep_entry_a: assert property ($rose(deep_sleep_active) |-> $past(deep_sleep_req, 2))
    else $error("sleep without request");
endmodule
bind clock_tree clock_tree_monitor mon_u (.mclk(mclk), .rst(rst), .free_running_clock(free_running_clock),
  .pll_locked_flag(pll_locked_flag), .sys_sel(sys_sel), .deep_sleep_req(deep_sleep_req),
  .wake_events(wake_events), .sys_tick(sys_tick), .pwm_aux_tick(pwm_aux_tick), .core_tick(core_tick),
  .mem_tick(mem_tick), .periph_tick(periph_tick), .free_run_tick(free_run_tick),
  .deep_sleep_active(deep_sleep_active), .wake_pulse(wake_pulse));

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import clock_tree_pkg::*;
  logic mclk, rst, fr, pl, lk, sel, bg, pg, dsr, act, cp, ppt, pt;
  logic [2:0] ad, bd, pd, wk;
  logic [15:0] ld;
  logic [3:0] lt;
  // Sinks: aux, bus, periph, then the four local ticks
  wire [6:0] tk = {lt, pt, ppt, cp};
  int gap [7], hits [7], fails, n_compared, cyc, h;
  clock_tree dut_u (.mclk(mclk), .rst(rst), .free_running_clock(fr), .pll_output_clock(pl),
    .pll_locked_flag(lk), .sys_sel(sel), .aux_div(ad), .bus_div(bd), .periph_div(pd), .bus_gate_en(bg),
    .periph_gate_en(pg), .periph_local_div(ld), .deep_sleep_req(dsr), .wake_events(wk), .sys_tick(),
    .pwm_aux_tick(cp), .core_tick(ppt), .mem_tick(), .periph_tick(pt), .periph_local_tick(lt),
    .free_run_tick(), .deep_sleep_active(act), .wake_pulse());
  for (genvar i = 0; i < 7; i++)
  begin : g_s
    tick_sink s_u (.mclk(mclk), .rst(rst), .tick(tk[i]),
      .gap(gap[i]), .hits(hits[i]));
  end
  function automatic int ratio(logic [3:0] d);
    return int'(d) + 1;
  endfunction
  task automatic chk(string n, int e, int g);
    n_compared++;
    if (e !== g)
    begin
      fails++;
      $display("MISMATCH %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    n_compared++;
    if (e !== g)
    begin
      fails++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  // Hang guard, runs far exceed the planned sequence
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    {rst, fr, pl, lk, sel, bg, pg, dsr, ad, bd, pd, wk, ld} = {8'hC6, 28'h0};
    void'($urandom(94));
    wt(5);
    rst = 0;
    // Longest divider chosen first, random after
    for (int i = 0; i < 6; i++)
    begin
      {ad, bd, pd} = i == 0 ? 9'h1FF : 9'($urandom);
      ld = i == 0 ? 16'h3333 : {4'($urandom % 4), 4'($urandom % 4), 4'($urandom % 4), 4'($urandom % 4)};
      wt(700);
      chk("aux gap", ratio(ad), gap[0]);
      chk("bus gap", ratio(bd), gap[1]);
      chk("periph gap", ratio(bd) * ratio(pd), gap[2]);
      for (int j = 0; j < 4; j++)
        chk("local gap", ratio(bd) * ratio(pd) * ratio(ld[j*4 +: 4]), gap[3 + j]);
    end
    {ad, bd, pd, pg} = 10'h0;
    wt(20);
    h = hits[2];
    wt(20);
    chk("periph gated", h, hits[2]);
    bg = 0;
    wt(20);
    h = hits[1];
    wt(20);
    chk("bus gated", h, hits[1]);
    {bg, pg, sel} = 3'h7;
    wt(20);
    h = hits[1];
    wt(20);
    chk("unlocked fallback", h + 20, hits[1]);
    lk = 1;
    wt(20);
    h = hits[1];
    wt(20);
    chk("locked no pll tick", h, hits[1]);
    {fr, pl} = 2'h1;
    wt(20);
    h = hits[1];
    wt(20);
    chk("pll ticks", h + 20, hits[1]);
    {fr, pl, lk, sel, dsr} = 5'h11;
    for (int k = 0; k < 3; k++)
    begin
      wt(6);
      chk_bit("sleeping", 1'h1, act);
      h = hits[0];
      wt(10);
      chk("aux in sleep", h, hits[0]);
      wk = 3'(1 << k);
      wt(1);
      wk = 0;
      wt(1);
      chk_bit("woken", 1'h0, act);
    end
    end_of_test();
  end
endmodule
